// ### src/clock_generation_control.sv
`timescale 1ns/1ns
// What this block does
// - Host and drive straps: dedicated clock is primary
// - Dedicated clock feeds halver, sync and outputs
// - Sync output: input clock or half, by strap
// - Each bus clock output has own enable
// - Host without drive: sync input is primary
// - System ratio: (1 + divide strap) times multiplier
// - Core ratio and multipliers from low config word
// - Engine ratio: multiplier over one plus divider
// - Memory clock: system times mode, halved out
// - Local bus clock: system times (1 + mode bit)
// - Local bus outputs divide by 2, 4, 8
// - Security clock: default third, full only <=166MHz
// - PCI/DMA clock: default full, switchable off
module clock_generation_control (
  input  wire logic                   clk_sys,
  input  wire logic                   arst_n,
  // Wishbone slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  // Straps and reset configuration
  input  wire logic                   host_mode_select,
  input  wire logic                   bus_clock_drive_select,
  input  wire logic                   input_divide_strap,
  input  wire logic                   hard_reset_option,
  input  wire logic [31:0]            reset_config_word_low,
  // Clock pins, sampled as ordinary inputs
  input  wire logic                   dedicated_clock_input,
  input  wire logic                   bus_clock_input,
  input  wire logic                   sync_clock_input,
  // Clock outputs
  output logic [clock_ctrl_pkg::NUM_BUS_CLK-1:0] bus_clock_output_n,
  output logic                        sync_clock_output,
  output logic [clock_ctrl_pkg::NUM_LOCAL_BUS_INTERNAL_CLOCK-1:0]  local_bus_clock_outputs,
  output logic                        local_bus_sync_output,
  output logic [1:0]                  memory_clock_pair,
  output logic                        security_clock_enable,
  output logic                        pci_dma_clock_enable,
  output logic [1:0]                  primary_source
);

  // Decoded system multiplier: code zero means sixteen
  function automatic logic [4:0] system_pll_multiplier_mult(input logic [3:0] code);
    if (code == clock_ctrl_pkg::SYSTEM_PLL_MULTIPLIER_CODE_16) begin
      return clock_ctrl_pkg::SYSTEM_PLL_MULTIPLIER_MULT_16;
    end
    return {1'b0, code};
  endfunction

  // Edge detector helper for the sampled clock pins
  function automatic logic rise(input logic now_v, input logic was_v);
    return now_v & ~was_v;
  endfunction

  // Pin synchronisers, one pair each, plus a history stage on each clock pin
  logic [2:0] strap_s1_q;            // First stage, straps
  logic [2:0] strap_s2_q;            // Second stage, straps
  logic       ref_s1_q;              // First stage, dedicated clock
  logic       ref_s2_q;              // Second stage, dedicated clock
  logic       ref_s3_q;              // History for edge detect
  logic       pcl_s1_q;              // First stage, bus clock pin
  logic       pcl_s2_q;
  logic       pcl_s3_q;
  logic       syn_s1_q;              // First stage, sync input
  logic       syn_s2_q;
  logic       syn_s3_q;

  // Configuration captured after reset release
  logic [1:0]                  settle_q;    // Synchroniser settle count
  logic                        captured_q;  // Straps are valid
  clock_ctrl_pkg::strap_t      strap_q;     // Latched straps
  clock_ctrl_pkg::rcw_low_t    rcw_q;       // Latched config word
  clock_ctrl_pkg::src_sel_t    src_q;       // Primary source
  logic                        full_ok_q;   // Security full rate allowed
  logic [31:0]                 csb_khz_d;   // System clock estimate

  // Software registers
  logic [clock_ctrl_pkg::NUM_BUS_CLK-1:0] out_en_q;   // Output enables
  logic [1:0]                  lb_div_q;    // Local bus divider field
  logic [1:0]                  sec_sel_q;   // Security clock select
  logic                        pci_en_q;    // PCI/DMA clock enable
  logic                        sec_refused_q; // Full rate was refused

  // Clock generation state
  logic                        half_q;      // Dedicated clock halved
  logic [clock_ctrl_pkg::NUM_BUS_CLK-1:0] gate_q; // Applied enables
  logic                        prim_tick;   // Primary clock rising edge
  logic                        ref_tick;    // Dedicated clock edge
  logic                        mem_tick_q;  // Memory clock edge
  logic                        mem_half_q;  // Memory clock phase
  logic [3:0]                  lb_ratio;    // Local bus divide ratio
  logic [3:0]                  sec_ratio;   // Security divide ratio
  logic [3:0]                  pci_ratio;   // PCI/DMA divide ratio
  logic                        lb_level;
  logic                        sec_pulse;
  logic                        pci_pulse;
  logic                        req;         // New bus request
  logic [31:0]                 rd_d;        // Read mux

  // Two-flop synchronisers for strap and clock pins; clock pins add a third stage that feeds edge detect
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      strap_s1_q <= 3'h0;
      strap_s2_q <= 3'h0;
      {ref_s1_q, ref_s2_q, ref_s3_q} <= 3'h0;
      {pcl_s1_q, pcl_s2_q, pcl_s3_q} <= 3'h0;
      {syn_s1_q, syn_s2_q, syn_s3_q} <= 3'h0;
    end else begin
      strap_s1_q <= {host_mode_select, bus_clock_drive_select,
                     input_divide_strap};
      strap_s2_q <= strap_s1_q;
      ref_s1_q   <= dedicated_clock_input;
      ref_s2_q   <= ref_s1_q;
      ref_s3_q   <= ref_s2_q;
      pcl_s1_q   <= bus_clock_input;
      pcl_s2_q   <= pcl_s1_q;
      pcl_s3_q   <= pcl_s2_q;
      syn_s1_q   <= sync_clock_input;
      syn_s2_q   <= syn_s1_q;
      syn_s3_q   <= syn_s2_q;
    end
  end

  // Estimated system clock: sync input times (1 + div) times multiplier
  always_comb begin
    csb_khz_d = clock_ctrl_pkg::SYNC_IN_KHZ *
                (32'd1 + {31'd0, strap_s2_q[0]}) *
                {27'd0, system_pll_multiplier_mult(hard_reset_option ?
                  clock_ctrl_pkg::RCW_HARD_DEFAULT.system_pll_multiplier :
                  reset_config_word_low[3:0])};
  end

  // Catch straps and config word once the synchronisers have settled
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      settle_q   <= 2'h0;
      captured_q <= 1'b0;
      strap_q    <= '0;
      rcw_q      <= '0;
      src_q      <= clock_ctrl_pkg::SRC_BUS_CLOCK;
      full_ok_q  <= 1'b0;
    end else if (!captured_q) begin
      if (settle_q != clock_ctrl_pkg::STRAP_SETTLE) begin
        settle_q <= settle_q + 2'h1;
      end else begin
        captured_q <= 1'b1;
        strap_q    <= strap_s2_q;
        // Pin word, or the hard-coded option
        rcw_q      <= hard_reset_option ?
                      clock_ctrl_pkg::RCW_HARD_DEFAULT :
                      reset_config_word_low;
        full_ok_q  <= csb_khz_d <= clock_ctrl_pkg::SEC_FULL_MAX_KHZ;
        // Primary source selection
        if (strap_s2_q[2] && strap_s2_q[1]) begin
          src_q <= clock_ctrl_pkg::SRC_DEDICATED;
        end else if (strap_s2_q[2]) begin
          src_q <= clock_ctrl_pkg::SRC_SYNC_IN;
        end else begin
          src_q <= clock_ctrl_pkg::SRC_BUS_CLOCK;
        end
      end
    end
  end

  // Edge ticks of the primary source and the dedicated clock
  always_comb begin
    ref_tick = rise(ref_s2_q, ref_s3_q);
    case (src_q)
      clock_ctrl_pkg::SRC_DEDICATED: prim_tick = ref_tick;
      clock_ctrl_pkg::SRC_SYNC_IN:   prim_tick = rise(syn_s2_q, syn_s3_q);
      clock_ctrl_pkg::SRC_BUS_CLOCK: prim_tick = rise(pcl_s2_q, pcl_s3_q);
      default:                       prim_tick = 1'b0;
    endcase
  end

  // Fixed halver of the dedicated clock, used only when driving
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      half_q <= 1'b0;
    end else if (src_q == clock_ctrl_pkg::SRC_DEDICATED && ref_tick) begin
      half_q <= ~half_q;
    end
  end

  // Enables are applied only while the halved clock is low, so a
  // change cannot chop a high phase short
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      gate_q <= '0;
    end else if (!half_q) begin
      gate_q <= out_en_q;
    end
  end

  // Bus clock outputs, each behind its own enable
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bus_clock_output_n <= '0;
    end else begin
      bus_clock_output_n <= (src_q == clock_ctrl_pkg::SRC_DEDICATED) ?
                            gate_q & {clock_ctrl_pkg::NUM_BUS_CLK{half_q}} :
                            '0;
    end
  end

  // Sync output: full input clock or the halved one
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync_clock_output <= 1'b0;
    end else if (src_q == clock_ctrl_pkg::SRC_DEDICATED) begin
      sync_clock_output <= strap_q.input_divide_strap ?
                           half_q : ref_s3_q;
    end else begin
      sync_clock_output <= 1'b0;
    end
  end

  // Memory clock pair: internal edges halved into a true/inverted pair;
  // a set mode bit doubles the internal rate, so every edge counts
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mem_tick_q <= 1'b0;
      mem_half_q <= 1'b0;
    end else if (prim_tick) begin
      mem_tick_q <= ~mem_tick_q;
      if (mem_tick_q || rcw_q.first_memctl_clock_mode) begin
        mem_half_q <= ~mem_half_q;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      memory_clock_pair <= 2'h0;
    end else begin
      memory_clock_pair <= captured_q ? {mem_half_q, ~mem_half_q} : 2'h0;
    end
  end

  // Local bus ratio; a set mode bit runs the internal clock at twice
  // the system rate, so the edge divider is halved
  always_comb begin
    case (lb_div_q)
      clock_ctrl_pkg::LB_DIV_2: lb_ratio = clock_ctrl_pkg::RATIO_2;
      clock_ctrl_pkg::LB_DIV_4: lb_ratio = clock_ctrl_pkg::RATIO_4;
      default:                  lb_ratio = clock_ctrl_pkg::RATIO_8;
    endcase
    if (!rcw_q.local_bus_clock_mode) begin
      lb_ratio = lb_ratio;
    end else begin
      lb_ratio = lb_ratio >> 1;
    end
    if (!captured_q) begin
      lb_ratio = clock_ctrl_pkg::RATIO_OFF;
    end
  end

  // Security and PCI/DMA ratios; full rate falls back to half when
  // the system clock is too fast for the security core
  always_comb begin
    case (sec_sel_q)
      clock_ctrl_pkg::SEC_OFF:  sec_ratio = clock_ctrl_pkg::RATIO_OFF;
      clock_ctrl_pkg::SEC_FULL: sec_ratio = full_ok_q ?
                                  clock_ctrl_pkg::RATIO_1 :
                                  clock_ctrl_pkg::RATIO_2;
      clock_ctrl_pkg::SEC_HALF: sec_ratio = clock_ctrl_pkg::RATIO_2;
      default:                  sec_ratio = clock_ctrl_pkg::RATIO_3;
    endcase
    pci_ratio = pci_en_q ? clock_ctrl_pkg::RATIO_1 :
                           clock_ctrl_pkg::RATIO_OFF;
  end

  // Local bus divider on primary clock edges
  unit_clock_divider u_lb_div (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .tick    (prim_tick),
    .ratio   (lb_ratio),
    .pulse   (),
    .level   (lb_level)
  );

  // Security core enable, system clock modelled by clk_sys
  unit_clock_divider u_sec_div (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .tick    (1'b1),
    .ratio   (sec_ratio),
    .pulse   (sec_pulse),
    .level   ()
  );

  // PCI and DMA complex enable
  unit_clock_divider u_pci_div (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .tick    (1'b1),
    .ratio   (pci_ratio),
    .pulse   (pci_pulse),
    .level   ()
  );

  // Registered clock and enable outputs
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      local_bus_clock_outputs <= '0;
      local_bus_sync_output   <= 1'b0;
      security_clock_enable   <= 1'b0;
      pci_dma_clock_enable    <= 1'b0;
      primary_source          <= 2'h0;
    end else begin
      local_bus_clock_outputs <= {clock_ctrl_pkg::NUM_LOCAL_BUS_INTERNAL_CLOCK{lb_level}};
      local_bus_sync_output   <= lb_level;
      security_clock_enable   <= sec_pulse;
      pci_dma_clock_enable    <= pci_pulse;
      primary_source          <= src_q;
    end
  end

  // A request is taken once; ack drops the cycle after
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Software writes; only byte lane 0 holds control fields
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      out_en_q      <= clock_ctrl_pkg::OUT_CLK_CTL_RST;
      lb_div_q      <= clock_ctrl_pkg::LB_DIV_RST;
      sec_sel_q     <= clock_ctrl_pkg::SEC_SEL_RST;
      pci_en_q      <= clock_ctrl_pkg::PCI_DMA_EN_RST;
      sec_refused_q <= 1'b0;
    end else if (req && wb_we_i && wb_sel_i[0]) begin
      case (wb_adr_i)
        clock_ctrl_pkg::OFS_OUT_CLK_CTL:
          out_en_q <= wb_dat_i[clock_ctrl_pkg::NUM_BUS_CLK-1:0];
        clock_ctrl_pkg::OFS_LB_RATIO:
          lb_div_q <= wb_dat_i[1:0];
        clock_ctrl_pkg::OFS_UNIT_CTL: begin
          sec_sel_q     <= wb_dat_i[1:0];
          pci_en_q      <= wb_dat_i[2];
          sec_refused_q <= wb_dat_i[1:0] == clock_ctrl_pkg::SEC_FULL &&
                           !full_ok_q;
        end
        default: ;
      endcase
    end
  end

  // Read mux; unmapped offsets answer zero
  always_comb begin
    rd_d = 32'h0;
    case (wb_adr_i)
      clock_ctrl_pkg::OFS_OUT_CLK_CTL:
        rd_d[clock_ctrl_pkg::NUM_BUS_CLK-1:0] = out_en_q;
      clock_ctrl_pkg::OFS_LB_RATIO:  rd_d[1:0] = lb_div_q;
      clock_ctrl_pkg::OFS_UNIT_CTL:  rd_d[3:0] = {sec_refused_q, pci_en_q,
                                                  sec_sel_q};
      clock_ctrl_pkg::OFS_CFG_STATUS:
        rd_d[6:0] = {full_ok_q, captured_q, src_q, strap_q};
      clock_ctrl_pkg::OFS_RCW_LOW:   rd_d = rcw_q;
      clock_ctrl_pkg::OFS_RATIO_STAT: begin
        // System ratio, engine numerator and denominator, mode ratios
        rd_d[5:0]   = {1'b0, system_pll_multiplier_mult(rcw_q.system_pll_multiplier)} <<
                      strap_q.input_divide_strap;
        rd_d[12:8]  = rcw_q.engine_pll_multiplier;
        rd_d[17:16] = 2'h1 + {1'b0, rcw_q.engine_pll_divider};
        rd_d[25:24] = 2'h1 + {1'b0, rcw_q.first_memctl_clock_mode};
        rd_d[29:28] = 2'h1 + {1'b0, rcw_q.local_bus_clock_mode};
      end
      default: rd_d = 32'h0;
    endcase
  end

  // Bus answer one cycle after the request appears
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_d : 32'h0;
    end
  end

endmodule

// ### common/clock_ctrl_pkg.sv
package clock_ctrl_pkg;

  // Count of individual bus clock outputs
  localparam int          NUM_BUS_CLK     = 5;
  // Count of local bus clock outputs
  localparam int          NUM_LOCAL_BUS_INTERNAL_CLOCK      = 3;

  // Register byte offsets
  localparam logic [7:0]  OFS_OUT_CLK_CTL = 8'h00;
  localparam logic [7:0]  OFS_LB_RATIO    = 8'h04;
  localparam logic [7:0]  OFS_UNIT_CTL    = 8'h08;
  localparam logic [7:0]  OFS_CFG_STATUS  = 8'h0c;
  localparam logic [7:0]  OFS_RCW_LOW     = 8'h10;
  localparam logic [7:0]  OFS_RATIO_STAT  = 8'h14;

  // Reset values
  localparam logic [NUM_BUS_CLK-1:0] OUT_CLK_CTL_RST = 5'h1f;
  localparam logic [1:0]  LB_DIV_RST      = 2'h0;
  localparam logic [1:0]  SEC_SEL_RST     = 2'h3;
  localparam logic        PCI_DMA_EN_RST  = 1'b1;

  // Local bus divider field codes
  localparam logic [1:0]  LB_DIV_2        = 2'h0;
  localparam logic [1:0]  LB_DIV_4        = 2'h1;
  // Security core clock select codes
  localparam logic [1:0]  SEC_OFF         = 2'h0;
  localparam logic [1:0]  SEC_FULL        = 2'h1;
  localparam logic [1:0]  SEC_HALF        = 2'h2;

  // Divider ratios, zero meaning clock stopped
  localparam logic [3:0]  RATIO_OFF       = 4'h0;
  localparam logic [3:0]  RATIO_1         = 4'h1;
  localparam logic [3:0]  RATIO_2         = 4'h2;
  localparam logic [3:0]  RATIO_3         = 4'h3;
  localparam logic [3:0]  RATIO_4         = 4'h4;
  localparam logic [3:0]  RATIO_8         = 4'h8;

  // System multiplier code that stands for sixteen
  localparam logic [3:0]  SYSTEM_PLL_MULTIPLIER_CODE_16    = 4'h0;
  localparam logic [4:0]  SYSTEM_PLL_MULTIPLIER_MULT_16    = 5'h10;

  // Sync input frequency in kHz and the security full-rate limit
  localparam int          SYNC_IN_KHZ     = 33333;
  localparam int          SEC_FULL_MAX_MHZ = 166;
  localparam int          SEC_FULL_MAX_KHZ = SEC_FULL_MAX_MHZ * 1000;

  // Cycles the strap synchronisers need before straps are trusted
  localparam logic [1:0]  STRAP_SETTLE    = 2'h3;

  // Low reset configuration word layout
  typedef struct packed {
    logic [12:0] reserved;
    logic        local_bus_clock_mode;
    logic        first_memctl_clock_mode;
    logic        engine_pll_divider;
    logic [4:0]  engine_pll_multiplier;
    logic [6:0]  core_pll_setting;
    logic [3:0]  system_pll_multiplier;
  } rcw_low_t;

  // Word used by the hard-coded reset option
  localparam rcw_low_t    RCW_HARD_DEFAULT = 32'h0000_0004;

  // Straps caught after reset
  typedef struct packed {
    logic host_mode_select;
    logic bus_clock_drive_select;
    logic input_divide_strap;
  } strap_t;

  // Primary clock source
  typedef enum logic [1:0] {
    SRC_DEDICATED,
    SRC_BUS_CLOCK,
    SRC_SYNC_IN
  } src_sel_t;

endpackage

// ### src/unit_clock_divider.sv
`timescale 1ns/1ns
// Divides a stream of tick pulses by a ratio; ratio zero stops the clock.
// A new ratio is only taken at a period boundary, so no short pulse or
// truncated high phase can appear at the output.
module unit_clock_divider (
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic       tick,
  input  wire logic [3:0] ratio,
  output logic            pulse,
  output logic            level
);

  logic [3:0] ratio_q;   // Ratio in force for the current period
  logic [3:0] count_q;   // Ticks seen within the current period

  // Count ticks; adopt a new ratio only when a period has ended
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ratio_q <= clock_ctrl_pkg::RATIO_OFF;
      count_q <= clock_ctrl_pkg::RATIO_OFF;
    end else if (count_q == clock_ctrl_pkg::RATIO_OFF) begin
      // Boundary: stopped or just wrapped
      ratio_q <= ratio;
      if (tick && ratio != clock_ctrl_pkg::RATIO_OFF &&
          ratio != clock_ctrl_pkg::RATIO_1) begin
        count_q <= clock_ctrl_pkg::RATIO_1;
      end
    end else if (tick) begin
      // Inside a period; wrap after the last tick
      if (count_q == ratio_q - clock_ctrl_pkg::RATIO_1) begin
        count_q <= clock_ctrl_pkg::RATIO_OFF;
      end else begin
        count_q <= count_q + clock_ctrl_pkg::RATIO_1;
      end
    end
  end

  // One pulse per period, on the period's first tick
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pulse <= 1'b0;
    end else begin
      pulse <= tick && count_q == clock_ctrl_pkg::RATIO_OFF &&
               ratio != clock_ctrl_pkg::RATIO_OFF;
    end
  end

  // Square clock: high over the first half of each period
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      level <= 1'b0;
    end else if (tick) begin
      if (count_q == clock_ctrl_pkg::RATIO_OFF) begin
        level <= ratio != clock_ctrl_pkg::RATIO_OFF;
      end else if ({count_q, 1'b0} >= {1'b0, ratio_q}) begin
        level <= 1'b0;
      end
    end
  end

endmodule

// ### tb/clock_ctrl_monitor.sv
`timescale 1ns/1ns
// Pin-level checks on the clock block; watches its ports only
module clock_ctrl_monitor (
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic [4:0]  bus_clock_output_n,
  input wire logic        sync_clock_output,
  input wire logic [2:0]  local_bus_clock_outputs,
  input wire logic        local_bus_sync_output,
  input wire logic [1:0]  memory_clock_pair,
  input wire logic [1:0]  primary_source
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // A fresh request, not the tail of an answered one
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_bus_rise; $rose(bus_clock_output_n[0]); endsequence
  property p_ack_next; s_req |=> wb_ack_o; endproperty
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  property p_pair; memory_clock_pair != 2'h3; endproperty
  property p_lb_same;
    local_bus_clock_outputs == {3{local_bus_sync_output}};
  endproperty
  property p_bus_src; primary_source != 2'h0 |-> bus_clock_output_n == 5'h0;
  endproperty
  property p_sync_src; primary_source != 2'h0 |-> !sync_clock_output;
  endproperty
  // A high phase shorter than three cycles would be a runt
  property p_bus_runt; s_bus_rise |-> bus_clock_output_n[0] [*3]; endproperty
  property p_sync_runt; $rose(sync_clock_output) |-> sync_clock_output [*3];
  endproperty
  property p_src_legal; primary_source != 2'h3; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack long");
  a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
  a_dat_idle: assert property (p_dat_idle) else $error("data idle");
  a_pair: assert property (p_pair) else $error("mem pair");
  a_lb_same: assert property (p_lb_same) else $error("lb outs");
  a_bus_src: assert property (p_bus_src) else $error("bus out");
  a_sync_src: assert property (p_sync_src) else $error("sync out");
  a_bus_runt: assert property (p_bus_runt) else $error("bus runt");
  a_sync_runt: assert property (p_sync_runt) else $error("sync runt");
  a_src_legal: assert property (p_src_legal) else $error("source");
endmodule
bind clock_generation_control clock_ctrl_monitor u_mon (.*);

// ### tb/board_clock_model.sv
`timescale 1ns/1ns
// Board oscillators; a 7 ns offset keeps pin edges off clk_sys edges
module board_clock_model (
  input  wire logic host_mode_select,
  output logic      dedicated_clock_input,
  output logic      bus_clock_input,
  output logic      sync_clock_input
);
  logic ded_q = 1'b0; // Dedicated oscillator, 16 clk_sys cycles
  logic bus_q = 1'b0; // Bus clock oscillator
  // Slow rates stand for pins that keep the system clock in range
  initial begin
    #7;
    fork
      forever #320 ded_q = ~ded_q;
      forever #360 bus_q = ~bus_q;
      forever #400 sync_clock_input = ~sync_clock_input;
    join
  end
  initial sync_clock_input = 1'b0;
  assign bus_clock_input = bus_q;
  // Agent boards tie the dedicated pin low
  assign dedicated_clock_input = ded_q & host_mode_select;
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic        clk_sys = 0, arst_n = 0, wb_cyc_i = 0, wb_stb_i = 0;
  logic        wb_we_i = 0, wb_ack_o, host_mode_select = 0;
  logic        bus_clock_drive_select = 0, input_divide_strap = 0;
  logic        hard_reset_option = 0, sync_clock_output;
  logic        dedicated_clock_input, bus_clock_input, sync_clock_input;
  logic        local_bus_sync_output, security_clock_enable;
  logic        pci_dma_clock_enable;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0, reset_config_word_low = 32'h0, wb_dat_o, rd;
  logic [4:0]  bus_clock_output_n, bor;
  logic [2:0]  local_bus_clock_outputs;
  logic [1:0]  memory_clock_pair, primary_source;
  int          failures = 0, compares = 0, n_sec, n_pci, n_lb, n_syn;
  always #20 clk_sys = ~clk_sys;
  clock_generation_control u_dut (.*);
  board_clock_model u_brd (.*);
  task automatic chk(input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Classic cycle: hold until ack is sampled, then release
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    if (n >= 20) failures++;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // Straps and word are caught once after release
  task automatic boot(input logic h, dv, dd, hr, input logic [31:0] w);
    @(posedge clk_sys);
    arst_n <= 1'b0;
    {host_mode_select, bus_clock_drive_select} <= {h, dv};
    input_divide_strap <= dd;
    hard_reset_option <= hr;
    reset_config_word_low <= w;
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
  endtask
  // Counts pulses and rises at settled points, after a settling gap.
  // The gap outlasts the longest divider period, so that a new ratio or
  // enable is in force; the window is a whole number of every period.
  task automatic meas();
    logic pl, ps;
    repeat (136) @(posedge clk_sys);
    @(negedge clk_sys);
    {n_sec, n_pci, n_lb, n_syn, bor} = '0;
    pl = local_bus_sync_output;
    ps = sync_clock_output;
    repeat (384) begin
      @(negedge clk_sys);
      n_sec += security_clock_enable;
      n_pci += pci_dma_clock_enable;
      n_lb += local_bus_sync_output && !pl;
      n_syn += sync_clock_output && !ps;
      bor |= bus_clock_output_n;
      pl = local_bus_sync_output;
      ps = sync_clock_output;
    end
  endtask
  task automatic t_host_drive();
    boot(1, 1, 1, 0, 32'h0003_2804);
    chk(primary_source, 2'h0);
    rc(8'h0c, 32'h27);
    rc(8'h10, 32'h0003_2804);
    rc(8'h14, 32'h1202_0508);
    rc(8'h00, 32'h1f);
    rc(8'h08, 32'h07);
    rc(8'h20, 32'h0);
    meas();
    chk(n_syn, 12);
    chk(n_sec, 128);
    chk(n_pci, 384);
    wb(1'b1, 8'h08, 32'h5);
    rc(8'h08, 32'h0d);
    meas();
    chk(n_sec, 192);
    wb(1'b1, 8'h08, 32'h0);
    meas();
    chk(n_sec, 0);
    chk(n_pci, 0);
    wb(1'b1, 8'h00, 32'h5);
    meas();
    chk({27'h0, bor}, 32'h05);
    for (int c = 0; c < 4; c++) begin
      wb(1'b1, 8'h04, c);
      meas();
      chk(n_lb, c == 0 ? 12 : c == 1 ? 6 : 3);
    end
  endtask
  task automatic t_others();
    boot(1, 1, 0, 1, 32'hffff_ffff);
    rc(8'h10, 32'h4);
    rc(8'h14, 32'h1101_0004);
    wb(1'b1, 8'h08, 32'h5);
    rc(8'h08, 32'h5);
    meas();
    chk(n_sec, 384);
    chk(n_syn, 24);
    boot(1, 0, 0, 1, 32'h0);
    rc(8'h0c, 32'h74);
    meas();
    chk({27'h0, bor}, 32'h0);
    chk(n_syn, 0);
    boot(0, 0, 0, 1, 32'h0);
    chk(primary_source, 2'h1);
  endtask
  task automatic final_report();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    t_host_drive();
    t_others();
    final_report();
  end
  // Watchdog well beyond the five thousand three hundred or so cycles the tests take
  initial begin
    #1000000;
    failures++;
    final_report();
  end
endmodule
